/* File: hw/ssx_pkg.sv */
// package: types and constants for the subtract/swap/skip execution block
package ssx_pkg;

  // ****************************************************************
  // register map (byte addresses on the control bus)
  // ****************************************************************
  localparam int SSX_ADDR_W = 12;
  localparam logic [11:0] SSX_REG_CTRL = 12'h000;
  localparam logic [11:0] SSX_REG_WREG = 12'h004;
  localparam logic [11:0] SSX_REG_STATUS = 12'h008;
  localparam logic [11:0] SSX_REG_SKIPS = 12'h00c;
  localparam logic [11:0] SSX_MEM_BASE = 12'h100;
  localparam logic [11:0] SSX_MEM_LAST = 12'h1fc;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int SSX_CTRL_EN_BIT = 0;
  localparam logic [31:0] SSX_CTRL_RESET = 32'h0000_0001;
  localparam logic [7:0] SSX_WREG_RESET = 8'h00;
  localparam logic [15:0] SSX_SKIPS_RESET = 16'h0000;
  localparam int SSX_FLAG_BORROW_INV_BIT = 0;
  localparam int SSX_FLAG_NIBBLE_BIT = 1;
  localparam int SSX_FLAG_NIL_BIT = 2;
  localparam int SSX_FLAG_WRAP_BIT = 3;
  localparam logic [1:0] SSX_RESP_OKAY = 2'h0;
  localparam logic [1:0] SSX_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // data memory and timing
  // ****************************************************************
  localparam int SSX_MEM_AW = 6;
  localparam int SSX_MEM_DEPTH = 64;
  localparam int SSX_CLK_PERIOD_PS = 5000;
  localparam int SSX_SKIP_CYCLES = 2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    SSX_OP_NOP,
    SSX_OP_SUB_MEM,
    SSX_OP_DIFF_MEM,
    SSX_OP_SUB_IMM,
    SSX_OP_SWAP,
    SSX_OP_XCHG_WR,
    SSX_OP_SKIP_NIL,
    SSX_OP_LOAD_SKIP,
    SSX_OP_BIT_SKIP
  } ssx_op_t;

  typedef enum logic {
    SSX_ST_RUN,
    SSX_ST_DUMMY
  } ssx_state_t;

  typedef struct packed {
    ssx_op_t op;
    logic [5:0] addr;
    logic [7:0] imm;
    logic [2:0] bit_sel;
  } ssx_issue_t;

  typedef struct packed {
    logic signed_wrap;
    logic nil_result;
    logic nibble_carry;
    logic borrow_inverse;
  } ssx_flags_t;

  typedef struct packed {
    logic [7:0] diff;
    ssx_flags_t flags;
  } ssx_sub_t;

endpackage : ssx_pkg

/* File: hw/ssx_exec.sv */
// execution unit for subtract, nibble swap and skip instructions with AXI4-Lite access
//
// Summary of operation
// - difference_to_memory writes working_register minus memory byte back to memory.
// - subtraction sets borrow_inverse when result non-negative; updates all four flags.
// - immediate subtract puts working_register minus constant into working_register.
// - in-place swap exchanges the two nibbles of the memory byte.
// - nibble_exchange_to_wr loads swapped memory byte into working_register, memory kept.
// - skip_on_nil skips the next instruction when the memory byte is zero.
// - taken skip inserts one dummy cycle, making the skip two cycles long.
// - load_skip_on_nil copies byte to working_register and skips when zero.
// - bit-test skip skips the next instruction when the selected bit is zero.
// - untaken skip continues with the next instruction, no extra cycle.
`timescale 1ns/1ps
module ssx_exec
  import ssx_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // instruction issue from the decoder
  input wire logic issue_valid,
  input wire ssx_issue_t issue,
  output logic issue_ready,
  output logic skip_taken,
  // core state
  output logic [7:0] working_register,
  output ssx_flags_t flags,
  // AXI4-Lite write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic ssx_sub_t ssx_subtract(input logic [7:0] a, input logic [7:0] b);
    ssx_sub_t r;
    r.diff = 8'(a - b);
    r.flags.borrow_inverse = (a >= b);
    r.flags.nibble_carry = (a[3:0] >= b[3:0]);
    r.flags.nil_result = (r.diff == 8'h00);
    r.flags.signed_wrap = (a[7] != b[7]) && (r.diff[7] != a[7]);
    return r;
  endfunction : ssx_subtract

  function automatic logic ssx_is_mem(input logic [11:0] a);
    return (a >= SSX_MEM_BASE) && (a <= SSX_MEM_LAST);
  endfunction : ssx_is_mem

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] mem [SSX_MEM_DEPTH];
  ssx_state_t state;
  logic [31:0] ctrl;
  logic [15:0] skip_count;
  logic ctrl_en;
  logic fire;
  logic [7:0] operand_m;
  ssx_sub_t sub_res;
  logic next_wr_en;
  logic [7:0] next_wr;
  logic next_flags_en;
  logic next_mem_en;
  logic [7:0] next_mem;
  logic next_skip;
  logic [11:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic write_go;
  logic sw_mem_we;
  logic [5:0] sw_mem_idx;
  logic [5:0] rd_mem_idx;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  assign ctrl_en = ctrl[SSX_CTRL_EN_BIT];
  assign fire = issue_valid && issue_ready;
  assign operand_m = mem[issue.addr];

  // ****************************************************************
  // instruction execution
  // ****************************************************************
  always_comb begin
    next_wr_en = 1'b0;
    next_wr = working_register;
    next_flags_en = 1'b0;
    next_mem_en = 1'b0;
    next_mem = operand_m;
    next_skip = 1'b0;
    sub_res = ssx_subtract(working_register, operand_m);
    unique case (issue.op)
      SSX_OP_NOP: begin
      end
      SSX_OP_SUB_MEM: begin
        next_wr_en = 1'b1;
        next_wr = sub_res.diff;
        next_flags_en = 1'b1;
      end
      SSX_OP_DIFF_MEM: begin
        next_mem_en = 1'b1;
        next_mem = sub_res.diff;
        next_flags_en = 1'b1;
      end
      SSX_OP_SUB_IMM: begin
        sub_res = ssx_subtract(working_register, issue.imm);
        next_wr_en = 1'b1;
        next_wr = sub_res.diff;
        next_flags_en = 1'b1;
      end
      SSX_OP_SWAP: begin
        next_mem_en = 1'b1;
        next_mem = {operand_m[3:0], operand_m[7:4]};
      end
      SSX_OP_XCHG_WR: begin
        next_wr_en = 1'b1;
        next_wr = {operand_m[3:0], operand_m[7:4]};
      end
      SSX_OP_SKIP_NIL: begin
        next_skip = (operand_m == 8'h00);
      end
      SSX_OP_LOAD_SKIP: begin
        next_wr_en = 1'b1;
        next_wr = operand_m;
        next_skip = (operand_m == 8'h00);
      end
      SSX_OP_BIT_SKIP: begin
        next_skip = !operand_m[issue.bit_sel];
      end
      default: begin
      end
    endcase
  end

  // ****************************************************************
  // skip sequencing
  // ****************************************************************
  // the dummy cycle holds off the next issue while fetch refills
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SSX_ST_RUN;
      issue_ready <= 1'b0;
      skip_taken <= 1'b0;
    end else begin
      skip_taken <= fire && next_skip;
      unique case (state)
        SSX_ST_RUN: begin
          if (fire && next_skip) begin
            state <= SSX_ST_DUMMY;
            issue_ready <= 1'b0;
          end else begin
            issue_ready <= ctrl_en;
          end
        end
        SSX_ST_DUMMY: begin
          state <= SSX_ST_RUN;
          issue_ready <= ctrl_en;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_count <= SSX_SKIPS_RESET;
    end else if (fire && next_skip) begin
      skip_count <= 16'(skip_count + 16'h0001);
    end
  end

  // ****************************************************************
  // working register and flags
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      working_register <= SSX_WREG_RESET;
    end else if (fire && next_wr_en) begin
      working_register <= next_wr;
    end else if (write_go && aw_addr == SSX_REG_WREG && w_strb[0]) begin
      working_register <= w_data[7:0];
    end
  end

  // swaps and skips never load the flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else if (fire && next_flags_en) begin
      flags <= sub_res.flags;
    end
  end

  // ****************************************************************
  // data memory
  // ****************************************************************
  assign sw_mem_idx = aw_addr[7:2];
  assign sw_mem_we = write_go && ssx_is_mem(aw_addr) && w_strb[0];

  always_ff @(posedge aclk) begin
    if (fire && next_mem_en) begin
      mem[issue.addr] <= next_mem;
    end else if (sw_mem_we) begin
      mem[sw_mem_idx] <= w_data[7:0];
    end
  end

  // ****************************************************************
  // AXI4-Lite write side
  // ****************************************************************
  // a bus write waits while an instruction executes, so neither is lost
  assign write_go = aw_held && w_held && !s_axi_bvalid && !fire;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SSX_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (write_go) begin
        s_axi_bvalid <= 1'b1;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        if (ssx_is_mem(aw_addr) || aw_addr == SSX_REG_CTRL || aw_addr == SSX_REG_WREG) begin
          s_axi_bresp <= SSX_RESP_OKAY;
        end else begin
          s_axi_bresp <= SSX_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= SSX_CTRL_RESET;
    end else if (write_go && aw_addr == SSX_REG_CTRL && w_strb[0]) begin
      ctrl <= {31'h0000_0000, w_data[SSX_CTRL_EN_BIT]};
    end
  end

  // ****************************************************************
  // AXI4-Lite read side
  // ****************************************************************
  assign rd_mem_idx = s_axi_araddr[7:2];

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = SSX_RESP_OKAY;
    if (ssx_is_mem(s_axi_araddr)) begin
      next_rdata = {24'h00_0000, mem[rd_mem_idx]};
    end else if (s_axi_araddr == SSX_REG_CTRL) begin
      next_rdata = ctrl;
    end else if (s_axi_araddr == SSX_REG_WREG) begin
      next_rdata = {24'h00_0000, working_register};
    end else if (s_axi_araddr == SSX_REG_STATUS) begin
      next_rdata = {28'h000_0000, flags};
    end else if (s_axi_araddr == SSX_REG_SKIPS) begin
      next_rdata = {16'h0000, skip_count};
    end else begin
      next_rresp = SSX_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= SSX_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // snapshot of each issued instruction, compared one cycle later
  logic h_valid;
  ssx_issue_t h_issue;
  logic [7:0] h_wr;
  logic [7:0] h_m;
  ssx_flags_t h_flags;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_valid <= 1'b0;
      h_issue <= '0;
      h_wr <= '0;
      h_m <= '0;
      h_flags <= '0;
    end else begin
      h_valid <= fire;
      h_issue <= issue;
      h_wr <= working_register;
      h_m <= operand_m;
      h_flags <= flags;
    end
  end

  default clocking ssx_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_diff_mem_result: assert property (
    h_valid && h_issue.op == SSX_OP_DIFF_MEM |->
      mem[h_issue.addr] == 8'(h_wr - h_m) && working_register == h_wr)
    else $error("difference not written to memory or working register moved");

  chk_sub_borrow_flag: assert property (
    h_valid && h_issue.op inside {SSX_OP_DIFF_MEM, SSX_OP_SUB_MEM} |->
      flags.borrow_inverse == (h_wr >= h_m) && flags.nil_result == (h_wr == h_m))
    else $error("subtract flags wrong");

  chk_imm_sub_result: assert property (
    h_valid && h_issue.op == SSX_OP_SUB_IMM |->
      working_register == 8'(h_wr - h_issue.imm) &&
      flags.borrow_inverse == (h_wr >= h_issue.imm))
    else $error("immediate subtract wrong");

  chk_swap_in_place: assert property (
    h_valid && h_issue.op == SSX_OP_SWAP |-> mem[h_issue.addr] == {h_m[3:0], h_m[7:4]})
    else $error("memory nibbles not exchanged");

  chk_swap_to_wr: assert property (
    h_valid && h_issue.op == SSX_OP_XCHG_WR |->
      working_register == {h_m[3:0], h_m[7:4]} && mem[h_issue.addr] == h_m)
    else $error("swap into working register wrong");

  chk_skip_on_zero: assert property (
    fire && issue.op == SSX_OP_SKIP_NIL |=> skip_taken == ($past(operand_m) == 8'h00))
    else $error("zero skip decision wrong");

  chk_dummy_cycle: assert property (
    fire && next_skip |=> !issue_ready && skip_taken ##1 !skip_taken)
    else $error("taken skip not followed by one dummy cycle");

  chk_load_skip: assert property (
    h_valid && h_issue.op == SSX_OP_LOAD_SKIP |->
      working_register == h_m && skip_taken == (h_m == 8'h00))
    else $error("load and skip wrong");

  chk_bit_skip: assert property (
    h_valid && h_issue.op == SSX_OP_BIT_SKIP |-> skip_taken == !h_m[h_issue.bit_sel])
    else $error("bit skip decision wrong");

  chk_no_extra_cycle: assert property (
    fire && !next_skip && ctrl_en && state == SSX_ST_RUN |=> issue_ready)
    else $error("untaken skip stalled the issue");

  chk_flags_kept: assert property (
    h_valid && h_issue.op inside {SSX_OP_SWAP, SSX_OP_XCHG_WR, SSX_OP_SKIP_NIL,
      SSX_OP_LOAD_SKIP, SSX_OP_BIT_SKIP} |-> flags == h_flags)
    else $error("flags moved by swap or skip");

endmodule : ssx_exec

/* File: test/ssx_decoder_model.sv */
// decoder model: offers one instruction at a time to the execution block
`timescale 1ns/1ps
module ssx_decoder_model
  import ssx_pkg::*;
(
  // clock
  input wire logic aclk,
  // instruction handshake
  input wire logic issue_ready,
  output logic issue_valid,
  output ssx_issue_t issue
);
  initial begin
    issue_valid = 1'b0;
    issue = '0;
  end

  // payload held until the taking edge, then scrambled so stale values never look valid
  task automatic send(input ssx_op_t op, input logic [5:0] addr, input logic [7:0] imm,
                      input logic [2:0] bit_sel, output bit ok);
    ok = 1'b0;
    @(posedge aclk);
    issue_valid <= 1'b1;
    issue <= '{op: op, addr: addr, imm: imm, bit_sel: bit_sel};
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge aclk);
      if (issue_ready) begin
        ok = 1'b1;
        issue_valid <= 1'b0;
        issue <= ssx_issue_t'(~issue);
      end
    end
  endtask : send
endmodule : ssx_decoder_model

/* File: test/tb_top.sv */
// testbench: instruction and AXI4-Lite sequences with expected values
`timescale 1ns/1ps
module tb_top;
  import ssx_pkg::*;
  // ****************************************************************
  // signals and tables
  // ****************************************************************
  localparam ssx_op_t op_diff_mem = ssx_op_t'(4'h2);
  localparam ssx_op_t op_xchg_wr = ssx_op_t'(4'h5);
  localparam ssx_op_t op_skip_nil = ssx_op_t'(4'h6);
  localparam ssx_op_t op_load_skip = ssx_op_t'(4'h7);
  localparam ssx_op_t op_bit_skip = ssx_op_t'(4'h8);
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic issue_valid, issue_ready, skip_taken;
  ssx_issue_t issue;
  logic [7:0] working_register;
  ssx_flags_t flags;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int failures = 0;
  int total_checks = 0;
  // boundary operands: plain, signed wrap down, zero result, signed wrap up
  logic [7:0] sub_a[4] = '{8'h50, 8'h80, 8'h3c, 8'h7f};
  logic [7:0] sub_b[4] = '{8'h60, 8'h01, 8'h3c, 8'hff};
  logic [7:0] sub_r[4] = '{8'hf0, 8'h7f, 8'h00, 8'h80};
  logic [3:0] sub_f[4] = '{4'b0010, 4'b1001, 4'b0111, 4'b1010};
  ssx_op_t sk_op[6] = '{op_skip_nil, op_skip_nil, op_load_skip, op_load_skip,
                        op_bit_skip, op_bit_skip};
  logic [5:0] sk_addr[6] = '{6'd4, 6'd5, 6'd4, 6'd5, 6'd5, 6'd5};
  logic [2:0] sk_bit[6] = '{3'd0, 3'd0, 3'd0, 3'd0, 3'd1, 3'd5};
  logic [0:0] sk_take[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [7:0] sk_val[6] = '{8'h00, 8'h21, 8'h00, 8'h21, 8'h21, 8'h21};

  always #2.5 aclk = ~aclk;

  ssx_exec dut_u (.aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid), .issue(issue),
    .issue_ready(issue_ready), .skip_taken(skip_taken), .working_register(working_register),
    .flags(flags), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ssx_decoder_model dec_u (.aclk(aclk), .issue_ready(issue_ready), .issue_valid(issue_valid),
    .issue(issue));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic test_done();
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic hang();
    failures++;
    test_done();
  endtask : hang

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [11:0] mem_a(input int k);
    return SSX_MEM_BASE + 12'(4 * k);
  endfunction : mem_a

  // address and data offered together, each released once taken
  task automatic put(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        check("bresp", {30'h0, bresp}, {30'h0, exp});
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) hang();
  endtask : put

  task automatic get(input string name, input logic [11:0] a, input logic [31:0] exp,
                     input logic [1:0] exp_resp);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        check(name, rdata, exp);
        check("rresp", {30'h0, rresp}, {30'h0, exp_resp});
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) hang();
  endtask : get

  task automatic run(input ssx_op_t op, input logic [5:0] a, input logic [7:0] imm,
                     input logic [2:0] b);
    bit ok;
    dec_u.send(op, a, imm, b, ok);
    if (!ok) hang();
    #1;
  endtask : run

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    check("flags_rst", {28'h0, flags}, 32'h0);
    get("ctrl", SSX_REG_CTRL, SSX_CTRL_RESET, SSX_RESP_OKAY);
    get("unmapped", 12'h040, 32'h0, SSX_RESP_SLVERR);
    put(12'h040, 32'h55, SSX_RESP_SLVERR);
    put(SSX_REG_STATUS, 32'hf, SSX_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      put(SSX_REG_WREG, {24'h0, sub_a[i]}, SSX_RESP_OKAY);
      run(SSX_OP_SUB_IMM, 6'd0, sub_b[i], 3'd0);
      check("sub_wr", {24'h0, working_register}, {24'h0, sub_r[i]});
      check("sub_flags", {28'h0, flags}, {28'h0, sub_f[i]});
    end
    get("status", SSX_REG_STATUS, 32'ha, SSX_RESP_OKAY);
    put(SSX_REG_WREG, 32'h50, SSX_RESP_OKAY);
    put(mem_a(1), 32'h30, SSX_RESP_OKAY);
    run(op_diff_mem, 6'd1, 8'h0, 3'd0);
    check("diff_wr", {24'h0, working_register}, 32'h50);
    check("diff_flags", {28'h0, flags}, 32'h3);
    get("diff_mem", mem_a(1), 32'h20, SSX_RESP_OKAY);
    put(mem_a(2), 32'ha5, SSX_RESP_OKAY);
    run(SSX_OP_SWAP, 6'd2, 8'h0, 3'd0);
    get("swap_mem", mem_a(2), 32'h5a, SSX_RESP_OKAY);
    put(mem_a(3), 32'h3c, SSX_RESP_OKAY);
    run(op_xchg_wr, 6'd3, 8'h0, 3'd0);
    check("xchg_wr", {24'h0, working_register}, 32'hc3);
    get("xchg_mem", mem_a(3), 32'h3c, SSX_RESP_OKAY);
    put(mem_a(4), 32'h0, SSX_RESP_OKAY);
    put(mem_a(5), 32'h21, SSX_RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      run(sk_op[i], sk_addr[i], 8'h0, sk_bit[i]);
      check("skip_pulse", {31'h0, skip_taken}, {31'h0, sk_take[i]});
      check("ready_gap", {31'h0, issue_ready}, {31'h0, ~sk_take[i]});
      if (sk_op[i] == op_load_skip) begin
        check("load_wr", {24'h0, working_register}, {24'h0, sk_val[i]});
      end
      check("skip_flags", {28'h0, flags}, 32'h3);
      @(posedge aclk);
      #1;
      check("pulse_end", {31'h0, skip_taken}, 32'h0);
    end
    get("skips", SSX_REG_SKIPS, 32'd3, SSX_RESP_OKAY);
    // plain subtract from memory: 0x21 - 0x21 gives zero, no borrow
    run(SSX_OP_SUB_MEM, 6'd5, 8'h0, 3'd0);
    check("sub_mem_wr", {24'h0, working_register}, 32'h0);
    check("sub_mem_flags", {28'h0, flags}, 32'h7);
    // issue enable cleared: the block must stop offering ready
    put(SSX_REG_CTRL, 32'h0, SSX_RESP_OKAY);
    @(posedge aclk);
    #1;
    check("ready_off", {31'h0, issue_ready}, 32'h0);
    get("ctrl_off", SSX_REG_CTRL, 32'h0, SSX_RESP_OKAY);
    put(SSX_REG_CTRL, 32'h1, SSX_RESP_OKAY);
    put(SSX_REG_SKIPS, 32'h5, SSX_RESP_SLVERR);
    get("skips_kept", SSX_REG_SKIPS, 32'd3, SSX_RESP_OKAY);
    test_done();
  end
endmodule : tb_top
